// ---- logic/hbd_cfg.svh ----
// constants for the half-bridge diagnostic and slew configuration bank
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define HBD_ADDR_SLEW_LO 8'h1D
`define HBD_ADDR_SLEW_HI 8'h1E
`define HBD_ADDR_OLDIS_LO 8'h1F
`define HBD_ADDR_OLOC_CTRL 8'h20
`define HBD_ADDR_OCF_TH_HI 8'h21
`define HBD_ADDR_OLTH_LO 8'h22

// -----------------------------------------------------------------
// reset values and field layout
// -----------------------------------------------------------------
`define HBD_REG_RESET 8'h00
`define HBD_RD_UNMAPPED 8'h00
`define HBD_HI_BRIDGE_MASK 8'h0F
`define HBD_OLOC_KEEP_MASK 8'hDF
`define HBD_OCF_TH_MASK 8'hEF
`define HBD_BIT_FAULT_MASK 7
`define HBD_BIT_KEEP_BRIDGE 6
`define HBD_BIT_OC_SLOW 4
`define HBD_POS_OC_FILT 5

// -----------------------------------------------------------------
// overcurrent deglitch times (ns) and cycles at the 20 MHz clock
// -----------------------------------------------------------------
`define HBD_CLK_MHZ 20
`define HBD_OCF_T0_NS 10000
`define HBD_OCF_T1_NS 5000
`define HBD_OCF_T2_NS 2500
`define HBD_OCF_T3_NS 1000
`define HBD_OCF_T4_NS 60000
`define HBD_OCF_T5_NS 40000
`define HBD_OCF_T6_NS 30000
`define HBD_OCF_T7_NS 20000
`define HBD_NS2CYC(t) (((t) * `HBD_CLK_MHZ) / 1000)

`endif

// ---- logic/hbd_pkg.sv ----
// types shared by the half-bridge configuration bank
package hbd_pkg;
  localparam int HBD_BRIDGES = 12;
  typedef logic [HBD_BRIDGES-1:0] hbd_vec_t;
  typedef logic [10:0] hbd_cyc_t;
  typedef logic [7:0] hbd_byte_t;
endpackage

// ---- logic/hbd_oc_if.sv ----
// overcurrent filter carrier between the bank and its deglitch unit
`timescale 1ns/1ns
`default_nettype none
interface hbd_oc_if;
  import hbd_pkg::*;
  hbd_vec_t ocRaw;
  hbd_cyc_t limit;
  hbd_vec_t trip;
  modport bank (output ocRaw, output limit, input trip);
  modport filt (input ocRaw, input limit, output trip);
endinterface
`default_nettype wire

// ---- logic/hbd_overcurrent_deglitch_sel.sv ----
// per-bridge overcurrent deglitch filter with pin synchronisers
`timescale 1ns/1ns
`default_nettype none
module hbd_overcurrent_deglitch_sel
  import hbd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  hbd_oc_if.filt oc
);

  // -----------------------------------------------------------------
  // two-flop synchroniser, then per-bridge counters
  // -----------------------------------------------------------------
  hbd_vec_t syncA_q, syncB_q;
  hbd_cyc_t cnt_q [HBD_BRIDGES];
  hbd_cyc_t cnt_d [HBD_BRIDGES];
  hbd_vec_t trip_d;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= oc.ocRaw;
      syncB_q <= syncA_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < HBD_BRIDGES; g++) begin : gBridge
      // count consecutive high samples, saturating at the limit
      always_comb begin
        cnt_d[g] = '0;
        if (syncB_q[g]) begin
          cnt_d[g] = (cnt_q[g] >= oc.limit) ? oc.limit : cnt_q[g] + 11'h001;
        end
        trip_d[g] = syncB_q[g] && (cnt_d[g] >= oc.limit);
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cnt_q[g] <= '0;
        end else begin
          cnt_q[g] <= cnt_d[g];
        end
      end
    end
  endgenerate

  hbd_vec_t trip_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trip_q <= '0;
    end else begin
      trip_q <= trip_d;
    end
  end
  assign oc.trip = trip_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_oc_deglitch;
    @(posedge sys_clk) disable iff (rst)
    $rose(trip_q[0]) |-> $past(cnt_q[0]) + 11'h001 >= $past(oc.limit);
  endproperty
  a_oc_deglitch: assert property (p_oc_deglitch)
    else $error("overcurrent tripped before its filter time");

endmodule
`default_nettype wire

// ---- logic/hbd_config_bank.sv ----
// half-bridge slew, open-load and overcurrent configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "hbd_cfg.svh"
module hbd_config_bank
  import hbd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [11:0] loadLossRaw,
  input wire logic [11:0] loadLossClear,
  input wire logic [11:0] overcurrentRaw,
  input wire logic [11:0] overcurrentClear,
  output logic [11:0] edgeRateFast,
  output logic [11:0] loadDetectOn,
  output logic [11:0] loadDetectLowTh,
  output logic overcurrentShutoffSlow,
  output logic [11:0] bridgeOff,
  output logic [11:0] loadLossFlag,
  output logic [11:0] overcurrentFlag,
  output logic faultOut,
  output logic faultOe
);

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  hbd_byte_t slewLo_q, slewLo_d, slewHi_q, slewHi_d;
  hbd_byte_t olDisLo_q, olDisLo_d, olOc_q, olOc_d;
  hbd_byte_t ocfTh_q, ocfTh_d, olThLo_q, olThLo_d;
  hbd_byte_t rd_q, rd_d;

  // write decode; reserved bits are dropped so they read zero
  always_comb begin
    slewLo_d = slewLo_q;
    slewHi_d = slewHi_q;
    olDisLo_d = olDisLo_q;
    olOc_d = olOc_q;
    ocfTh_d = ocfTh_q;
    olThLo_d = olThLo_q;
    if (regWrEn) begin
      case (regAddr)
        `HBD_ADDR_SLEW_LO: slewLo_d = regWrData;
        `HBD_ADDR_SLEW_HI: slewHi_d = regWrData & `HBD_HI_BRIDGE_MASK;
        `HBD_ADDR_OLDIS_LO: olDisLo_d = regWrData;
        `HBD_ADDR_OLOC_CTRL: olOc_d = regWrData & `HBD_OLOC_KEEP_MASK;
        `HBD_ADDR_OCF_TH_HI: ocfTh_d = regWrData & `HBD_OCF_TH_MASK;
        `HBD_ADDR_OLTH_LO: olThLo_d = regWrData;
        default: ;
      endcase
    end
  end

  // registered read data, unmapped reads return zero
  always_comb begin
    case (regAddr)
      `HBD_ADDR_SLEW_LO: rd_d = slewLo_q;
      `HBD_ADDR_SLEW_HI: rd_d = slewHi_q;
      `HBD_ADDR_OLDIS_LO: rd_d = olDisLo_q;
      `HBD_ADDR_OLOC_CTRL: rd_d = olOc_q;
      `HBD_ADDR_OCF_TH_HI: rd_d = ocfTh_q;
      `HBD_ADDR_OLTH_LO: rd_d = olThLo_q;
      default: rd_d = `HBD_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slewLo_q <= `HBD_REG_RESET;
      slewHi_q <= `HBD_REG_RESET;
      olDisLo_q <= `HBD_REG_RESET;
      olOc_q <= `HBD_REG_RESET;
      ocfTh_q <= `HBD_REG_RESET;
      olThLo_q <= `HBD_REG_RESET;
      rd_q <= `HBD_REG_RESET;
    end else begin
      slewLo_q <= slewLo_d;
      slewHi_q <= slewHi_d;
      olDisLo_q <= olDisLo_d;
      olOc_q <= olOc_d;
      ocfTh_q <= ocfTh_d;
      olThLo_q <= olThLo_d;
      rd_q <= rd_d;
    end
  end
  assign regRdData = rd_q;

  // -----------------------------------------------------------------
  // configuration outputs, live straight from the registers
  // -----------------------------------------------------------------
  logic maskFault, keepBridge;
  assign edgeRateFast = {slewHi_q[3:0], slewLo_q};
  assign loadDetectOn = ~{olOc_q[3:0], olDisLo_q};
  assign loadDetectLowTh = {ocfTh_q[3:0], olThLo_q};
  assign overcurrentShutoffSlow = olOc_q[`HBD_BIT_OC_SLOW];
  assign maskFault = olOc_q[`HBD_BIT_FAULT_MASK];
  assign keepBridge = olOc_q[`HBD_BIT_KEEP_BRIDGE];

  // deglitch select to cycle limit, picked up on the next sample
  hbd_cyc_t ocLimit;
  always_comb begin
    case (ocfTh_q[7:`HBD_POS_OC_FILT])
      3'h0: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T0_NS));
      3'h1: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T1_NS));
      3'h2: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T2_NS));
      3'h3: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T3_NS));
      3'h4: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T4_NS));
      3'h5: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T5_NS));
      3'h6: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T6_NS));
      3'h7: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T7_NS));
      default: ocLimit = 11'(`HBD_NS2CYC(`HBD_OCF_T0_NS));
    endcase
  end

  hbd_oc_if ocBus ();
  assign ocBus.ocRaw = overcurrentRaw;
  assign ocBus.limit = ocLimit;
  hbd_overcurrent_deglitch_sel uOcFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .oc(ocBus.filt)
  );

  // -----------------------------------------------------------------
  // open-load sync, sticky flags, bridge shutoff and fault pin
  // -----------------------------------------------------------------
  hbd_vec_t olSyncA_q, olSyncB_q;
  hbd_vec_t olFlag_q, olFlag_d, ocFlag_q, ocFlag_d, off_q, off_d;
  logic faultOe_q, faultOe_d;

  // a new event wins over a clear in the same cycle
  always_comb begin
    olFlag_d = ((olFlag_q & ~loadLossClear) | olSyncB_q) & loadDetectOn;
    ocFlag_d = (ocFlag_q & ~overcurrentClear) | ocBus.trip;
    off_d = ocFlag_d | (keepBridge ? '0 : olFlag_d);
    faultOe_d = (|olFlag_d && !maskFault) || (|ocFlag_d);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      olSyncA_q <= '0;
      olSyncB_q <= '0;
      olFlag_q <= '0;
      ocFlag_q <= '0;
      off_q <= '0;
      faultOe_q <= 1'b0;
    end else begin
      olSyncA_q <= loadLossRaw;
      olSyncB_q <= olSyncA_q;
      olFlag_q <= olFlag_d;
      ocFlag_q <= ocFlag_d;
      off_q <= off_d;
      faultOe_q <= faultOe_d;
    end
  end
  assign loadLossFlag = olFlag_q;
  assign overcurrentFlag = ocFlag_q;
  assign bridgeOff = off_q;
  assign faultOe = faultOe_q; // pulls the active-low fault line down
  assign faultOut = 1'b0;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_slew_lo;
    regWrEn && regAddr == `HBD_ADDR_SLEW_LO |=>
      edgeRateFast[7:0] == $past(regWrData);
  endproperty
  a_slew_lo: assert property (p_slew_lo)
    else $error("slew select not applied after write");

  property p_slew_hi_rsvd;
    regWrEn && regAddr == `HBD_ADDR_SLEW_HI ##1
      regAddr == `HBD_ADDR_SLEW_HI |=> regRdData[7:4] == 4'h0;
  endproperty
  a_slew_hi_rsvd: assert property (p_slew_hi_rsvd)
    else $error("reserved slew bits not zero");

  property p_ol_disabled;
    ((olFlag_q & ~$past(olFlag_q)) & ~$past(loadDetectOn)) == '0;
  endproperty
  a_ol_disabled: assert property (p_ol_disabled)
    else $error("open-load flag rose on disabled bridge");

  property p_oldis_hi;
    regWrEn && regAddr == `HBD_ADDR_OLOC_CTRL |=>
      loadDetectOn[11:8] == ~$past(regWrData[3:0]);
  endproperty
  a_oldis_hi: assert property (p_oldis_hi)
    else $error("upper open-load disable bits wrong");

  property p_fault_mask;
    (|olFlag_q) && !maskFault && !$past(maskFault) |-> faultOe;
  endproperty
  a_fault_mask: assert property (p_fault_mask)
    else $error("unmasked open load not driving fault pin");

  property p_ol_shutoff;
    !$past(keepBridge) |-> (olFlag_q & ~bridgeOff) == '0;
  endproperty
  a_ol_shutoff: assert property (p_ol_shutoff)
    else $error("bridge left on after open load");

  property p_oc_slew;
    regWrEn && regAddr == `HBD_ADDR_OLOC_CTRL |=>
      overcurrentShutoffSlow == $past(regWrData[4]);
  endproperty
  a_oc_slew: assert property (p_oc_slew)
    else $error("overcurrent turn-off slew not applied");

  property p_th_hi;
    regWrEn && regAddr == `HBD_ADDR_OCF_TH_HI |=>
      loadDetectLowTh[11:8] == $past(regWrData[3:0]) && ocfTh_q[4] == 1'b0;
  endproperty
  a_th_hi: assert property (p_th_hi)
    else $error("upper threshold bits wrong");

  property p_th_lo;
    regWrEn && regAddr == `HBD_ADDR_OLTH_LO |=>
      loadDetectLowTh[7:0] == $past(regWrData);
  endproperty
  a_th_lo: assert property (p_th_lo)
    else $error("lower threshold bits not applied");

endmodule
`default_nettype wire

// ---- verification/hbd_host_model.sv ----
// host-side model driving the parallel register port
`timescale 1ns/1ns
`default_nettype none
module hbd_host_model (
  input wire logic sys_clk,
  output logic regWrEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  // idle port at time zero
  initial begin
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #5;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge sys_clk);
    #5;
    regWrEn = 1'b0;
    regWrData = ~d; // stale data no longer valid
  endtask

  // present address, take data one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #5;
    regAddr = a;
    @(posedge sys_clk);
    #1;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ---- verification/hbd_config_bank_test.sv ----
// self-checking bench for the half-bridge configuration bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module hbd_config_bank_test;
  import hbd_pkg::*;
  logic sys_clk, rst, regWrEn, faultOut, faultOe, ocSlow;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic [11:0] llRaw, llClr, ocRaw, ocClr, edgeFast, detOn, lowTh;
  logic [11:0] bridgeOff, llFlag, ocFlag;
  int failures = 0, comparisons = 0, cycles = 0, cnt;
  logic [7:0] addrs[6] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
  logic [7:0] wdat[6] = '{8'hA5, 8'hFA, 8'h3C, 8'hF5, 8'hFF, 8'h81};
  logic [7:0] rexp[6] = '{8'hA5, 8'h0A, 8'h3C, 8'hD5, 8'hEF, 8'h81};
  int nTab[8] = '{200, 100, 50, 20, 1200, 800, 600, 400};

  hbd_config_bank hbd_config_bank_i (.sys_clk(sys_clk), .rst(rst),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .loadLossRaw(llRaw), .loadLossClear(llClr),
    .overcurrentRaw(ocRaw), .overcurrentClear(ocClr),
    .edgeRateFast(edgeFast), .loadDetectOn(detOn),
    .loadDetectLowTh(lowTh), .overcurrentShutoffSlow(ocSlow),
    .bridgeOff(bridgeOff), .loadLossFlag(llFlag),
    .overcurrentFlag(ocFlag), .faultOut(faultOut), .faultOe(faultOe));
  hbd_host_model hbd_host_model_i (.sys_clk(sys_clk), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // let n edges pass, land just after the last
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {llRaw, llClr, ocRaw, ocClr} = '0;
    step(6);
    rst = 1'b0;
    // reset values of every register and of the edge, detect, threshold, slew and fault pin outputs
    for (int i = 0; i < 6; i++) begin
      hbd_host_model_i.rd(addrs[i], rdv);
      `CHK(rdv, 8'h00)
    end
    `CHK(edgeFast, 12'h000)
    `CHK(detOn, 12'hFFF)
    `CHK(lowTh, 12'h000)
    `CHK(ocSlow, 1'b0)
    `CHK(faultOut, 1'b0)
    // reserved ones written on purpose to 1E, 20 and 21
    for (int i = 0; i < 6; i++) begin
      hbd_host_model_i.wr(addrs[i], wdat[i]);
    end
    for (int i = 0; i < 6; i++) begin
      hbd_host_model_i.rd(addrs[i], rdv);
      `CHK(rdv, rexp[i])
    end
    `CHK(edgeFast, 12'hAA5)
    `CHK(detOn, 12'hAC3)
    `CHK(lowTh, 12'hF81)
    `CHK(ocSlow, 1'b1)
    hbd_host_model_i.wr(8'h23, 8'hFF);
    hbd_host_model_i.rd(8'h23, rdv);
    `CHK(rdv, 8'h00)
    hbd_host_model_i.wr(8'h1E, 8'h05);
    `CHK(edgeFast[11:8], 4'h5)
    // open load, unmasked and switching off; bridge 2 disabled
    hbd_host_model_i.wr(8'h20, 8'h00);
    hbd_host_model_i.wr(8'h1F, 8'h04);
    `CHK(ocSlow, 1'b0)
    llRaw = 12'h005;
    step(2);
    `CHK(llFlag, 12'h000)
    step(1);
    `CHK(llFlag, 12'h001)
    `CHK(bridgeOff, 12'h001)
    `CHK(faultOe, 1'b1)
    llRaw = '0;
    step(4);
    llClr = 12'hFFF;
    step(1);
    llClr = '0;
    step(2);
    `CHK(llFlag, 12'h000)
    `CHK(faultOe, 1'b0)
    `CHK(bridgeOff, 12'h000)
    // masked and kept active
    hbd_host_model_i.wr(8'h20, 8'hC0);
    llRaw = 12'h002;
    step(3);
    `CHK(llFlag, 12'h002)
    `CHK(bridgeOff, 12'h000)
    `CHK(faultOe, 1'b0)
    llRaw = '0;
    step(4);
    llClr = 12'hFFF;
    step(1);
    llClr = '0;
    // every deglitch code, fault pin unmasked for overcurrent
    for (int c = 0; c < 8; c++) begin
      hbd_host_model_i.wr(8'h21, {3'(c), 5'h00});
      ocRaw = 12'h001;
      cnt = 0;
      while (ocFlag[0] !== 1'b1 && cnt < 1300) begin
        step(1);
        cnt++;
      end
      `CHK(cnt >= nTab[c] + 1 && cnt <= nTab[c] + 4, 1'b1)
      `CHK(faultOe, 1'b1)
      `CHK(bridgeOff[0], 1'b1)
      ocRaw = '0;
      step(4);
      ocClr = 12'hFFF;
      step(1);
      ocClr = '0;
      step(1);
      `CHK(ocFlag, 12'h000)
    end
    // mid-run reset clears registers and flags
    hbd_host_model_i.wr(8'h1D, 8'hFF);
    llRaw = 12'h001;
    step(3);
    `CHK(llFlag, 12'h001)
    rst = 1'b1;
    llRaw = '0;
    step(2);
    rst = 1'b0;
    `CHK(llFlag, 12'h000)
    `CHK(edgeFast, 12'h000)
    `CHK(detOn, 12'hFFF)
    hbd_host_model_i.rd(8'h1D, rdv);
    `CHK(rdv, 8'h00)
    final_report();
  end
endmodule
`default_nettype wire
